/* File: core/pwfs_top.sv */
// Wake-event collector with APB registers and UART queue control copies.
`include "pwfs_params.svh"
module pwfs_top
	import pwfs_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        main_rstn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        uart_a_qctl_we_i,
	input  wire logic        uart_b_qctl_we_i,
	input  wire logic [7:0]  uart_qctl_data_i,
	input  wire logic        ring_wake_port_one_i,
	input  wire logic        ring_wake_port_two_i,
	input  wire logic        keyboard_wake_i,
	input  wire logic        mouse_wake_i,
	output logic             wake_request_n_o
);
	// rstn_i is the standby-supply power-on reset. main_rstn_i stands for
	// main-supply, soft and hard reset; the wake registers ignore it.

	pwfs_byte_t      qctl_a_r;
	pwfs_byte_t      qctl_b_r;
	logic            wake_master_enable_r;
	logic            wake_pending_flag_r;
	pwfs_byte_t      wake_source_enable_r;
	pwfs_byte_t      src_status;
	pwfs_byte_t      src_event;
	pwfs_byte_t      src_clear;
	pwfs_byte_t      rdata_nxt;
	logic            wr_en;
	logic            rd_en;
	logic            wake_nxt;
	logic            hit;
	logic [7:0]      reg_ofs;
	pwfs_apb_state_t apb_state_r;

	assign reg_ofs = paddr_i[`PWFS_ADDR_MSB:`PWFS_ADDR_LSB];
	assign wr_en   = psel_i && penable_i && pwrite_i && pready_o;
	assign rd_en   = psel_i && !penable_i && !pwrite_i;

	// Slave answers with no wait state: pready rises in the first access cycle.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			apb_state_r <= PWFS_IDLE;
			pready_o    <= 1'b0;
		end else begin
			case (apb_state_r)
				PWFS_IDLE: begin
					pready_o <= 1'b0;
					if (psel_i && !penable_i) begin
						apb_state_r <= PWFS_SETUP;
						pready_o    <= 1'b1;
					end
				end
				PWFS_SETUP: begin
					apb_state_r <= PWFS_ACCESS;
					pready_o    <= 1'b0;
				end
				default: begin
					pready_o <= 1'b0;
					if (psel_i && !penable_i) begin
						apb_state_r <= PWFS_SETUP;
						pready_o    <= 1'b1;
					end else begin
						apb_state_r <= PWFS_IDLE;
					end
				end
			endcase
		end
	end

	// Copies follow the UART control writes; the main reset clears them
	// because they shadow main-supply logic.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			qctl_a_r <= `PWFS_RST_VAL;
			qctl_b_r <= `PWFS_RST_VAL;
		end else if (!main_rstn_i) begin
			qctl_a_r <= `PWFS_RST_VAL;
			qctl_b_r <= `PWFS_RST_VAL;
		end else begin
			if (uart_a_qctl_we_i) begin
				qctl_a_r <= uart_qctl_data_i;
			end
			if (uart_b_qctl_we_i) begin
				qctl_b_r <= uart_qctl_data_i;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wake_master_enable_r <= 1'b0;
			wake_source_enable_r <= `PWFS_RST_VAL;
		end else if (wr_en) begin
			// No main reset term here.
			if (reg_ofs == `PWFS_OFS_WCTL) begin
				wake_master_enable_r <= pwdata_i[`PWFS_BIT_MASTER];
			end else if (reg_ofs == `PWFS_OFS_WEN) begin
				wake_source_enable_r <= pwdata_i[7:0] & `PWFS_SRC_MASK;
			end
		end
	end

	assign src_event[0]               = 1'b0;
	assign src_event[`PWFS_BIT_RING2] = ring_wake_port_two_i;
	assign src_event[`PWFS_BIT_RING1] = ring_wake_port_one_i;
	assign src_event[`PWFS_BIT_KBD]   = keyboard_wake_i;
	assign src_event[`PWFS_BIT_MOUSE] = mouse_wake_i;
	assign src_event[7:5]             = 3'h0;

	// Only written ones inside the clearable field act.
	assign src_clear = (wr_en && reg_ofs == `PWFS_OFS_WSRC) ?
		(pwdata_i[7:0] & `PWFS_W1C_MASK) : 8'h00;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_src
			if (((`PWFS_SRC_MASK >> g) & 8'h01) != 8'h00) begin : g_live
				// Held across main reset.
				pwfs_event_bit u_bit (
					.core_clk_i (core_clk_i),
					.stby_rstn_i(rstn_i),
					.event_i    (src_event[g]),
					.clear_i    (src_clear[g]),
					.flag_o     (src_status[g])
				);
			end else begin : g_rsvd
				assign src_status[g] = 1'b0;
			end
		end
	endgenerate

	// Pending flag sets on any enabled source event regardless of master.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wake_pending_flag_r <= 1'b0;
		end else if ((src_event & wake_source_enable_r) != 8'h00) begin
			wake_pending_flag_r <= 1'b1;
		end else if (wr_en && reg_ofs == `PWFS_OFS_WSTAT &&
				pwdata_i[`PWFS_BIT_PENDING]) begin
			wake_pending_flag_r <= 1'b0;
		end
	end

	// Output needs the pending flag, the master enable and a live enabled
	// source, so clearing either status ends the assertion.
	assign wake_nxt = wake_master_enable_r && wake_pending_flag_r &&
		((src_status & wake_source_enable_r) != 8'h00);

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wake_request_n_o <= 1'b1;
		end else begin
			wake_request_n_o <= !wake_nxt;
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		hit       = 1'b1;
		if (reg_ofs == `PWFS_OFS_QCTL_A) begin
			rdata_nxt[`PWFS_QCTL_LOW] = qctl_a_r[`PWFS_QCTL_LOW];
			rdata_nxt[`PWFS_QCTL_THR] = qctl_a_r[`PWFS_QCTL_THR];
		end else if (reg_ofs == `PWFS_OFS_QCTL_B) begin
			rdata_nxt[`PWFS_QCTL_LOW] = qctl_b_r[`PWFS_QCTL_LOW];
			rdata_nxt[`PWFS_QCTL_THR] = qctl_b_r[`PWFS_QCTL_THR];
		end else if (reg_ofs == `PWFS_OFS_WCTL) begin
			rdata_nxt[`PWFS_BIT_MASTER] = wake_master_enable_r;
		end else if (reg_ofs == `PWFS_OFS_WSTAT) begin
			rdata_nxt[`PWFS_BIT_PENDING] = wake_pending_flag_r;
		end else if (reg_ofs == `PWFS_OFS_WSRC) begin
			rdata_nxt = src_status;
		end else if (reg_ofs == `PWFS_OFS_WEN) begin
			rdata_nxt = wake_source_enable_r;
		end else begin
			hit = 1'b0;
		end
	end

	// Read data is registered in the setup cycle and presented with pready.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (psel_i && !penable_i) begin
			prdata_o  <= rd_en ? {24'h00_0000, rdata_nxt} : 32'h0000_0000;
			pslverr_o <= !hit || (pwrite_i && (paddr_i[1:0] != 2'b00));
		end else if (!psel_i) begin
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end
	end

	// A wake runs in three steps: an enabled event, both flags one cycle
	// later and the pin one cycle after that. A register write in the event
	// cycle may change the enables, so it is left out of the start.
	sequence s_wake_start;
		wake_master_enable_r && !wr_en &&
		((src_event & wake_source_enable_r) != 8'h00);
	endsequence

	sequence s_flags_up;
		wake_pending_flag_r &&
		((src_status & wake_source_enable_r) != 8'h00);
	endsequence

	sequence s_pin_low;
		!wake_request_n_o;
	endsequence

	// Clearing the pending flag with no enabled event in flight drops the
	// flag at once and releases the pin one cycle later.
	sequence s_pend_clear;
		wr_en && (reg_ofs == `PWFS_OFS_WSTAT) &&
		pwdata_i[`PWFS_BIT_PENDING] &&
		((src_event & wake_source_enable_r) == 8'h00);
	endsequence

	sequence s_pin_released;
		!wake_pending_flag_r ##1 wake_request_n_o;
	endsequence

	AST_MASTER_GATE: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		!wake_master_enable_r |=> wake_request_n_o)
		else $error("wake output asserted with master enable low");

	AST_SRC_STICKY: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(src_status[`PWFS_BIT_MOUSE] && !src_clear[`PWFS_BIT_MOUSE])
		|=> src_status[`PWFS_BIT_MOUSE])
		else $error("mouse status bit dropped without a clear");

	AST_RING_SET: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		ring_wake_port_two_i |=> src_status[`PWFS_BIT_RING2])
		else $error("port-two ring status not set");

	AST_RING1_SET: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		ring_wake_port_one_i |=> src_status[`PWFS_BIT_RING1])
		else $error("port-one ring status not set");

	AST_KBD_SET: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		keyboard_wake_i |=> src_status[`PWFS_BIT_KBD])
		else $error("keyboard status not set");

	AST_MOUSE_SET: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		mouse_wake_i |=> src_status[`PWFS_BIT_MOUSE])
		else $error("mouse status not set");

	AST_W1C_SRC: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(src_clear[`PWFS_BIT_KBD] && !keyboard_wake_i)
		|=> !src_status[`PWFS_BIT_KBD])
		else $error("keyboard status not cleared by write of one");

	AST_W1C_ZERO: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(wr_en && (reg_ofs == `PWFS_OFS_WSRC) &&
		!pwdata_i[`PWFS_BIT_KBD] && src_status[`PWFS_BIT_KBD])
		|=> src_status[`PWFS_BIT_KBD])
		else $error("keyboard status lost on a write of zero");

	AST_PEND_SET: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		((src_event & wake_source_enable_r) != 8'h00)
		|=> wake_pending_flag_r)
		else $error("pending flag not set on enabled event");

	AST_WAKE_ON: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		s_wake_start |=> s_flags_up ##1 s_pin_low)
		else $error("wake output not asserted two cycles after event");

	AST_HOLD_WAKE: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(wake_master_enable_r ##0 s_flags_up) |=> s_pin_low)
		else $error("wake output released while an enabled source is set");

	AST_DISABLED_QUIET: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(wake_source_enable_r == 8'h00) [*2] |-> wake_request_n_o)
		else $error("wake output asserted with every source disabled");

	AST_DIS_NO_PEND: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		((src_event != 8'h00) && !wake_pending_flag_r &&
		((src_event & wake_source_enable_r) == 8'h00))
		|=> !wake_pending_flag_r)
		else $error("disabled source event set the pending flag");

	AST_RSVD_ZERO: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(pready_o && !pwrite_i && (reg_ofs == `PWFS_OFS_QCTL_A ||
		reg_ofs == `PWFS_OFS_QCTL_B))
		|-> prdata_o[`PWFS_QCTL_RSVD] == 2'b00)
		else $error("reserved queue control bits read nonzero");

	AST_MAIN_RST_KEEP: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!main_rstn_i && !wr_en) |=> $stable(wake_master_enable_r))
		else $error("master enable lost on main reset");

	AST_MAIN_RST_PEND: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!main_rstn_i && !wr_en && wake_pending_flag_r)
		|=> wake_pending_flag_r)
		else $error("pending flag lost on main reset");

	AST_MAIN_RST_SRC: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!main_rstn_i && src_status[`PWFS_BIT_KBD] &&
		!src_clear[`PWFS_BIT_KBD]) |=> src_status[`PWFS_BIT_KBD])
		else $error("source status lost on main reset");

	AST_MAIN_RST_EN: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!main_rstn_i && !wr_en) |=> $stable(wake_source_enable_r))
		else $error("source enables lost on main reset");

	AST_PEND_CLEAR: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		s_pend_clear |=> s_pin_released)
		else $error("pending clear did not end wake output");

	AST_PEND_ZERO_WR: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(wr_en && (reg_ofs == `PWFS_OFS_WSTAT) &&
		!pwdata_i[`PWFS_BIT_PENDING] && wake_pending_flag_r)
		|=> wake_pending_flag_r)
		else $error("pending flag lost on a write of zero");

	AST_QCTL_A_COPY: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(uart_a_qctl_we_i && main_rstn_i)
		|=> qctl_a_r == $past(uart_qctl_data_i))
		else $error("queue copy a did not take the written value");

	AST_QCTL_B_COPY: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(uart_b_qctl_we_i && main_rstn_i)
		|=> qctl_b_r == $past(uart_qctl_data_i))
		else $error("queue copy b did not take the written value");
endmodule

/* File: core/pwfs_params.svh */
// Constants for the wake-event collector and the queue control copies.
// Summary of operation
// - Both queue control copies show queue enable in bit 0, receive clear in bit 1, transmit clear in bit 2 and DMA mode in bit 3.
// - Both copies show the receive threshold in bits 7 and 6 and read bits 5 and 4 as zero.
// - Bit 0 of the wake control register is the master enable; with it at 0 the wake output never asserts.
// - The master enable survives main power-on reset, soft reset and hard reset.
// - The wake pending flag sets whenever the wake output would assert, whatever the master enable.
// - Writing 1 to the wake pending flag clears it and ends the output; writing 0 does nothing.
// - The wake pending flag survives main power-on reset, soft reset and hard reset.
// - The source status register sets bit 1 for port-two ring, 2 for port-one ring, 3 for keyboard, 4 for mouse.
// - Writing 1 to bits 4 to 0 of the source status clears them; writing 0 has no effect.
// - The source status survives main power-on reset, soft reset and hard reset.
// - An enabled source with the master enable set drives the wake output active.
// - A disabled source is still recorded but does not assert the wake output.
// - The source enable register survives main power-on reset, soft reset and hard reset.
// - The four wake registers clear to zero only on the standby-supply power-on reset.
`ifndef PWFS_PARAMS_SVH
`define PWFS_PARAMS_SVH
`define PWFS_OFS_QCTL_A   8'hC3
`define PWFS_OFS_QCTL_B   8'hC4
`define PWFS_OFS_WCTL     8'hC5
`define PWFS_OFS_WSTAT    8'hC6
`define PWFS_OFS_WSRC     8'hC7
`define PWFS_OFS_WEN      8'hC8
`define PWFS_ADDR_LSB     2
`define PWFS_ADDR_MSB     9
`define PWFS_RST_VAL      8'h00
`define PWFS_QCTL_LOW     3:0
`define PWFS_QCTL_THR     7:6
`define PWFS_QCTL_RSVD    5:4
`define PWFS_SRC_MASK     8'h1E
`define PWFS_W1C_MASK     8'h1F
`define PWFS_BIT_MASTER   0
`define PWFS_BIT_PENDING  0
`define PWFS_BIT_RING2    1
`define PWFS_BIT_RING1    2
`define PWFS_BIT_KBD      3
`define PWFS_BIT_MOUSE    4
`endif

/* File: core/pwfs_pkg.sv */
// Types shared by the wake-event collector.
package pwfs_pkg;
	typedef logic [7:0] pwfs_byte_t;
	typedef enum logic [1:0] {
		PWFS_IDLE,
		PWFS_SETUP,
		PWFS_ACCESS
	} pwfs_apb_state_t;
endpackage

/* File: core/pwfs_event_bit.sv */
// One sticky wake-source status bit with write-one-to-clear.
module pwfs_event_bit (
	input  wire logic core_clk_i,
	input  wire logic stby_rstn_i,
	input  wire logic event_i,
	input  wire logic clear_i,
	output logic      flag_o
);
	// Set wins over a clear in the same cycle so no event is lost.
	always_ff @(posedge core_clk_i or negedge stby_rstn_i) begin
		if (!stby_rstn_i) begin
			flag_o <= 1'b0;
		end else if (event_i) begin
			flag_o <= 1'b1;
		end else if (clear_i) begin
			flag_o <= 1'b0;
		end
	end
endmodule

/* File: bench/pwfs_host_pm.sv */
// Host power-management side that watches the active-low wake request.
module pwfs_host_pm (
	input  wire logic core_clk_i,
	input  wire logic rstn_i,
	input  wire logic wake_request_n_i,
	output logic      wake_seen_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// The request is a level held until software clears it, so sampling it
	// once per clock loses nothing.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wake_seen_o <= 1'h0;
		end else begin
			wake_seen_o <= ~wake_request_n_i;
		end
	end
endmodule

/* File: bench/testbench.sv */
// Register-level testbench for the wake-event collector.
`include "pwfs_params.svh"
module testbench import pwfs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'h0;
	logic        rstn = 1'h0;
	logic        main_rstn = 1'h1;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        qa_we = 1'h0;
	logic        qb_we = 1'h0;
	pwfs_byte_t  qdata = 8'h00;
	logic [3:0]  ev = 4'h0;
	logic        wake_n;
	logic        wake_seen;
	logic [31:0] q;
	logic        e;
	int          err_total = 0;
	int          comparisons = 0;
	pwfs_byte_t  regs [6] = '{`PWFS_OFS_QCTL_A, `PWFS_OFS_QCTL_B,
		`PWFS_OFS_WCTL, `PWFS_OFS_WSTAT, `PWFS_OFS_WSRC, `PWFS_OFS_WEN};

	always #2.5 clk = ~clk;

	pwfs_top u_dut (.core_clk_i(clk), .rstn_i(rstn), .main_rstn_i(main_rstn),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .uart_a_qctl_we_i(qa_we),
		.uart_b_qctl_we_i(qb_we), .uart_qctl_data_i(qdata),
		.ring_wake_port_one_i(ev[1]), .ring_wake_port_two_i(ev[0]),
		.keyboard_wake_i(ev[2]), .mouse_wake_i(ev[3]),
		.wake_request_n_o(wake_n));

	pwfs_host_pm u_host (.core_clk_i(clk), .rstn_i(rstn),
		.wake_request_n_i(wake_n), .wake_seen_o(wake_seen));

	task automatic close_out();
		$display("checks %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] got);
		comparisons++;
		if (got !== x) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, x, got);
		end
	endtask

	// The request is held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input pwfs_byte_t ofs,
		input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= {22'h0, ofs, 2'h0};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// Only the watchdog ends a wait that never sees pready.
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rd(input string nm, input pwfs_byte_t ofs,
		input logic [31:0] x);
		apb(1'h0, ofs, 32'h0);
		chk(nm, x, q);
		chk("pslverr", 32'h0, {31'h0, e});
	endtask

	task automatic rd_zero();
		foreach (regs[i]) rd("reset value", regs[i], 32'h0);
	endtask

	task automatic qwr(input logic b, input pwfs_byte_t d);
		@(posedge clk);
		qa_we <= ~b;
		qb_we <= b;
		qdata <= d;
		@(posedge clk);
		qa_we <= 1'h0;
		qb_we <= 1'h0;
	endtask

	task automatic fire(input int i);
		@(posedge clk);
		ev[i] <= 1'h1;
		@(posedge clk);
		ev[i] <= 1'h0;
		repeat (4) @(posedge clk);
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		close_out();
	end

	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'h1;
		rd_zero();
		qwr(1'h0, 8'hFF);
		qwr(1'h1, 8'h3A);
		rd("queue copy a", `PWFS_OFS_QCTL_A, 32'hCF);
		rd("queue copy b", `PWFS_OFS_QCTL_B, 32'h0A);
		apb(1'h0, 8'hC9, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		fire(3);
		rd("disabled source", `PWFS_OFS_WSRC, 32'h10);
		rd("pending", `PWFS_OFS_WSTAT, 32'h0);
		chk("wake", 32'h0, {31'h0, wake_seen});
		apb(1'h1, `PWFS_OFS_WSRC, 32'h1F);
		rd("source cleared", `PWFS_OFS_WSRC, 32'h0);
		apb(1'h1, `PWFS_OFS_WEN, 32'hFF);
		rd("enables", `PWFS_OFS_WEN, 32'h1E);
		for (int i = 0; i < 4; i++) begin
			fire(i);
			rd("source bit", `PWFS_OFS_WSRC, 32'h2 << i);
			rd("pending", `PWFS_OFS_WSTAT, 32'h1);
			chk("masked wake", 32'h0, {31'h0, wake_seen});
			apb(1'h1, `PWFS_OFS_WSRC, 32'h1F);
			apb(1'h1, `PWFS_OFS_WSTAT, 32'h1);
		end
		apb(1'h1, `PWFS_OFS_WCTL, 32'hFF);
		rd("master", `PWFS_OFS_WCTL, 32'h1);
		fire(2);
		chk("wake", 32'h1, {31'h0, wake_seen});
		apb(1'h1, `PWFS_OFS_WSRC, 32'h0);
		apb(1'h1, `PWFS_OFS_WSTAT, 32'h0);
		rd("zero write", `PWFS_OFS_WSRC, 32'h08);
		rd("zero write", `PWFS_OFS_WSTAT, 32'h1);
		@(posedge clk);
		main_rstn <= 1'h0;
		@(posedge clk);
		main_rstn <= 1'h1;
		rd("master kept", `PWFS_OFS_WCTL, 32'h1);
		rd("pending kept", `PWFS_OFS_WSTAT, 32'h1);
		rd("source kept", `PWFS_OFS_WSRC, 32'h08);
		rd("enable kept", `PWFS_OFS_WEN, 32'h1E);
		rd("copy reset", `PWFS_OFS_QCTL_A, 32'h0);
		rd("copy reset b", `PWFS_OFS_QCTL_B, 32'h0);
		chk("wake held", 32'h1, {31'h0, wake_seen});
		apb(1'h1, `PWFS_OFS_WSTAT, 32'h1);
		repeat (3) @(posedge clk);
		chk("wake ended", 32'h0, {31'h0, wake_seen});
		rd("pending clear", `PWFS_OFS_WSTAT, 32'h0);
		apb(1'h1, `PWFS_OFS_WSRC, 32'h1F);
		fire(1);
		chk("wake", 32'h1, {31'h0, wake_seen});
		@(posedge clk);
		rstn <= 1'h0;
		repeat (2) @(posedge clk);
		chk("wake in reset", 32'h1, {31'h0, wake_n});
		rstn <= 1'h1;
		rd_zero();
		close_out();
	end
endmodule
